//--- verilog/sdpd_top.sv
// power-down and reset sequencing of the memory device
`default_nettype none
module sdpd_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // memory pins
  input wire logic CKE,
  input wire logic RESET_N,
  input wire logic ODT,
  input wire logic [3:0] CMD,
  input wire logic [2:0] BA,
  input wire logic A10,
  input wire logic [sdpd_pkg::MR0_WR_W-1:0] MR0_WR,
  input wire logic MR0_PPD,
  // status
  output logic IN_BUF_EN,
  output logic OUT_BUF_EN,
  output logic DLL_ON,
  output logic TERM_ON,
  output logic ACT_PD,
  output logic PRE_PD,
  output logic IN_RESET,
  output logic [sdpd_pkg::MR0_WR_W-1:0] WR_RECOVERY,
  output logic [sdpd_pkg::CNT_W-1:0] REF_COUNT
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers (two flops before any logic)
  logic [13:0] s1_r, s2_r;
  logic rst_s1_r, rst_s2_r;
  // mode fields ride with the command bits, so an MRS sees its own field values
  wire [13:0] pins = {CKE, ODT, CMD, BA, A10, MR0_WR, MR0_PPD};
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end
  // device reset pin acts asynchronously, released through two flops
  wire dev_rst_n = RSTN && RESET_N;
  always_ff @(posedge CLK or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  // one flat word keeps the pin order in a single place
  logic cke_s, odt_s, a10_s, mr0_ppd_s;
  logic [3:0] cmd_s;
  logic [2:0] ba_s;
  logic [sdpd_pkg::MR0_WR_W-1:0] mr0_wr_s;
  assign {cke_s, odt_s, cmd_s, ba_s, a10_s, mr0_wr_s, mr0_ppd_s} = s2_r;
  ////////////////////////////////////////////////////////////////////////////
  // command decode
  sdpd_ctl_if ctl ();
  sdpd_cmd_dec u_dec (
    .cmd(cmd_s),
    .ba(ba_s),
    .a10(a10_s),
    .ctl(ctl)
  );
  ////////////////////////////////////////////////////////////////////////////
  // state
  sdpd_pkg::sdpd_state_e state_r, state_nxt;
  logic [sdpd_pkg::BANKS-1:0] open_r, open_nxt;
  logic dll_r, dll_nxt;
  logic [sdpd_pkg::CNT_W-1:0] ref_cnt_r;
  logic [sdpd_pkg::MR0_WR_W-1:0] wr_r;
  logic ppd_fast_r;
  logic cke_prev_r;
  wire in_pd = (state_r == sdpd_pkg::SDPD_ACT_PD) || (state_r == sdpd_pkg::SDPD_PRE_PD);
  wire pd_enter = cke_prev_r && !cke_s && ctl.is_nop;
  wire pd_exit = in_pd && cke_s && ctl.is_nop;
  wire any_open = |open_r;
  // commands only act while out of power-down
  wire cmd_live = (state_r == sdpd_pkg::SDPD_IDLE) && cke_s && cke_prev_r;
  ////////////////////////////////////////////////////////////////////////////
  // bank tracking
  function automatic logic [sdpd_pkg::BANKS-1:0] bank_bit(input logic [2:0] b);
    bank_bit = {{(sdpd_pkg::BANKS-1){1'b0}}, 1'b1} << b;
  endfunction
  always_comb begin
    open_nxt = open_r;
    if (cmd_live && ctl.is_act) begin
      open_nxt = open_r | bank_bit(ctl.bank);
    end else if (cmd_live && ctl.is_pre) begin
      open_nxt = ctl.pre_all ? '0 : (open_r & ~bank_bit(ctl.bank));
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // power state machine
  always_comb begin
    state_nxt = state_r;
    dll_nxt = dll_r;
    unique case (state_r)
      sdpd_pkg::SDPD_RESET: begin
        if (rst_s2_r) begin
          state_nxt = sdpd_pkg::SDPD_IDLE;
          dll_nxt = 1'b1;
        end
      end
      sdpd_pkg::SDPD_IDLE: begin
        if (pd_enter && any_open) begin
          state_nxt = sdpd_pkg::SDPD_ACT_PD;
        end else if (pd_enter) begin
          state_nxt = sdpd_pkg::SDPD_PRE_PD;
          dll_nxt = ppd_fast_r;
        end
      end
      sdpd_pkg::SDPD_ACT_PD, sdpd_pkg::SDPD_PRE_PD: begin
        if (pd_exit) begin
          state_nxt = sdpd_pkg::SDPD_IDLE;
          dll_nxt = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge CLK or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      // async reset drops any power-down state
      state_r <= sdpd_pkg::SDPD_RESET;
      open_r <= '0;
      dll_r <= 1'b0;
      cke_prev_r <= 1'b0;
    end else if (!rst_s2_r) begin
      state_r <= sdpd_pkg::SDPD_RESET;
      open_r <= '0;
      dll_r <= 1'b0;
      cke_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      open_r <= open_nxt;
      dll_r <= dll_nxt;
      cke_prev_r <= cke_s;
    end
  end
  // mode fields captured on MRS; refresh counter survives device reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_r <= '0;
      ppd_fast_r <= 1'b0;
      ref_cnt_r <= '0;
    end else begin
      if (cmd_live && ctl.is_mrs) begin
        wr_r <= mr0_wr_s;
        ppd_fast_r <= mr0_ppd_s;
      end
      if (cmd_live && ctl.is_ref) begin
        ref_cnt_r <= ref_cnt_r + {{(sdpd_pkg::CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  wire rst_st = (state_r == sdpd_pkg::SDPD_RESET);
  assign IN_BUF_EN = !in_pd && !rst_st;
  assign OUT_BUF_EN = !in_pd && !rst_st;
  assign DLL_ON = dll_r;
  // termination follows ODT pin, never with DLL off or in reset
  assign TERM_ON = odt_s && dll_r && !rst_st;
  assign ACT_PD = (state_r == sdpd_pkg::SDPD_ACT_PD);
  assign PRE_PD = (state_r == sdpd_pkg::SDPD_PRE_PD);
  assign IN_RESET = rst_st;
  assign WR_RECOVERY = wr_r;
  assign REF_COUNT = ref_cnt_r;
  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_entry;
    @(posedge CLK) disable iff (!dev_rst_n)
    (state_r == sdpd_pkg::SDPD_IDLE) && pd_enter && rst_s2_r |=> in_pd;
  endproperty
  a_entry: assert property (p_entry) else $error("power-down not entered");
  property p_act;
    @(posedge CLK) disable iff (!dev_rst_n)
    (state_r == sdpd_pkg::SDPD_IDLE) && pd_enter && any_open && rst_s2_r |=> ACT_PD && DLL_ON;
  endproperty
  a_act: assert property (p_act) else $error("active power-down wrong");
  property p_pre;
    @(posedge CLK) disable iff (!dev_rst_n)
    (state_r == sdpd_pkg::SDPD_IDLE) && pd_enter && !any_open && rst_s2_r |=> PRE_PD;
  endproperty
  a_pre: assert property (p_pre) else $error("precharge power-down wrong");
  property p_slow;
    @(posedge CLK) disable iff (!dev_rst_n)
    PRE_PD |-> (DLL_ON == ppd_fast_r);
  endproperty
  a_slow: assert property (p_slow) else $error("dll state mismatch");
  property p_buf;
    @(posedge CLK) disable iff (!dev_rst_n)
    in_pd |-> !IN_BUF_EN && !OUT_BUF_EN;
  endproperty
  a_buf: assert property (p_buf) else $error("buffers on in power-down");
  property p_exit;
    @(posedge CLK) disable iff (!dev_rst_n)
    pd_exit && rst_s2_r |=> (state_r == sdpd_pkg::SDPD_IDLE) && DLL_ON;
  endproperty
  a_exit: assert property (p_exit) else $error("power-down not exited");
  property p_rst;
    @(posedge CLK) disable iff (!RSTN)
    !rst_s2_r |-> IN_RESET && !OUT_BUF_EN && !TERM_ON;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs wrong");
  property p_term;
    @(posedge CLK) disable iff (!dev_rst_n)
    !DLL_ON |-> !TERM_ON;
  endproperty
  a_term: assert property (p_term) else $error("termination with dll off");
  property p_ign;
    @(posedge CLK) disable iff (!dev_rst_n)
    in_pd |=> $stable(open_r);
  endproperty
  a_ign: assert property (p_ign) else $error("command acted in power-down");
  c_act: cover property (@(posedge CLK) ACT_PD ##1 !ACT_PD);
  c_pre_slow: cover property (@(posedge CLK) PRE_PD && !DLL_ON);
  c_pd_rst: cover property (@(posedge CLK) in_pd ##1 !RESET_N);
  // limitation: a device reset pulse shorter than one clock can trip the checks below
  property p_rst_pd;
    @(posedge CLK) disable iff (!RSTN)
    !rst_s2_r |-> !ACT_PD && !PRE_PD;
  endproperty
  a_rst_pd: assert property (p_rst_pd) else $error("power-down kept in reset");
  property p_wr;
    @(posedge CLK) disable iff (!dev_rst_n)
    cmd_live && ctl.is_mrs |=> WR_RECOVERY == $past(mr0_wr_s);
  endproperty
  a_wr: assert property (p_wr) else $error("write recovery not captured");
  property p_ppd;
    @(posedge CLK) disable iff (!dev_rst_n)
    cmd_live && ctl.is_mrs |=> ppd_fast_r == $past(mr0_ppd_s);
  endproperty
  a_ppd: assert property (p_ppd) else $error("exit type not captured");
  property p_ref;
    @(posedge CLK) disable iff (!dev_rst_n)
    cmd_live && ctl.is_ref |=> REF_COUNT != $past(REF_COUNT);
  endproperty
  a_ref: assert property (p_ref) else $error("refresh not counted");
  property p_mrs_ign;
    @(posedge CLK) disable iff (!dev_rst_n)
    in_pd && ctl.is_mrs |=> $stable(WR_RECOVERY) && $stable(ppd_fast_r);
  endproperty
  a_mrs_ign: assert property (p_mrs_ign) else $error("mode set acted in power-down");
  property p_act_dll;
    @(posedge CLK) disable iff (!dev_rst_n)
    ACT_PD |-> DLL_ON;
  endproperty
  a_act_dll: assert property (p_act_dll) else $error("dll off in active power-down");
  property p_idle_stay;
    @(posedge CLK) disable iff (!dev_rst_n)
    (state_r == sdpd_pkg::SDPD_IDLE) && !pd_enter |=> !in_pd;
  endproperty
  a_idle_stay: assert property (p_idle_stay) else $error("power-down without entry");
  property p_wake;
    @(posedge CLK) disable iff (!dev_rst_n)
    $fell(in_pd) && rst_s2_r |-> IN_BUF_EN && OUT_BUF_EN;
  endproperty
  a_wake: assert property (p_wake) else $error("buffers off after exit");
  property p_stay_pd;
    @(posedge CLK) disable iff (!dev_rst_n)
    in_pd && !(cke_s && ctl.is_nop) && rst_s2_r |=> in_pd;
  endproperty
  a_stay_pd: assert property (p_stay_pd) else $error("power-down left without exit");
  property p_pre_dll;
    @(posedge CLK) disable iff (!dev_rst_n)
    (state_r == sdpd_pkg::SDPD_IDLE) && pd_enter && !any_open && rst_s2_r |=>
      DLL_ON == $past(ppd_fast_r);
  endproperty
  a_pre_dll: assert property (p_pre_dll) else $error("dll wrong at precharge entry");
  property p_rst_dll;
    @(posedge CLK) disable iff (!RSTN)
    IN_RESET |-> !DLL_ON;
  endproperty
  a_rst_dll: assert property (p_rst_dll) else $error("dll on in reset");
  c_fast: cover property (@(posedge CLK) PRE_PD && DLL_ON);
  c_ref: cover property (@(posedge CLK) cmd_live && ctl.is_ref);
endmodule
`default_nettype wire

//--- verilog/sdpd_pkg.sv
// package: command codes, power states, mode register fields and timing constants
`default_nettype none
package sdpd_pkg;
  // command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [0:0] CS_DESELECT = 1'h1;
  // mode register 0 fields
  localparam int MR0_PPD_BIT = 12;
  localparam int MR0_WR_LSB = 9;
  localparam int MR0_WR_W = 3;
  localparam int BANKS = 8;
  localparam logic [2:0] BANK_MSB = 3'h7;
  // timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int RESET_MIN_NS = 100;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;
  typedef enum logic [1:0] {
    SDPD_IDLE,
    SDPD_ACT_PD,
    SDPD_PRE_PD,
    SDPD_RESET
  } sdpd_state_e;
endpackage
`default_nettype wire

//--- verilog/sdpd_ctl_if.sv
// interface: command decode results passed from the decoder to the power-down core
`default_nettype none
interface sdpd_ctl_if;
  logic is_nop;
  logic is_act;
  logic is_pre;
  logic is_mrs;
  logic is_ref;
  logic is_rw;
  logic [2:0] bank;
  logic pre_all;
  modport dec (output is_nop, is_act, is_pre, is_mrs, is_ref, is_rw, bank, pre_all);
  modport core (input is_nop, is_act, is_pre, is_mrs, is_ref, is_rw, bank, pre_all);
endinterface
`default_nettype wire

//--- verilog/sdpd_cmd_dec.sv
// command decoder for the registered command pins
`default_nettype none
module sdpd_cmd_dec (
  // command pins, already synchronised
  input wire logic [3:0] cmd,
  input wire logic [2:0] ba,
  input wire logic a10,
  // decoded
  sdpd_ctl_if.dec ctl
);
  wire deselect = (cmd[3] == sdpd_pkg::CS_DESELECT);
  assign ctl.is_nop = deselect || (cmd == sdpd_pkg::CMD_NOP);
  assign ctl.is_act = !deselect && (cmd == sdpd_pkg::CMD_ACT);
  assign ctl.is_pre = !deselect && (cmd == sdpd_pkg::CMD_PRE);
  assign ctl.is_mrs = !deselect && (cmd == sdpd_pkg::CMD_MRS);
  assign ctl.is_ref = !deselect && (cmd == sdpd_pkg::CMD_REF);
  assign ctl.is_rw = !deselect && ((cmd == sdpd_pkg::CMD_WR) || (cmd == sdpd_pkg::CMD_RD));
  assign ctl.bank = ba;
  assign ctl.pre_all = a10;
endmodule
`default_nettype wire

//--- verif/sdpd_ctl_model.sv
// memory controller model driving the device pins
`default_nettype none
module sdpd_ctl_model #(
  parameter int TPD = 4,
  parameter int TXP = 4,
  parameter int RST_CYC = 10
) (
  // clock
  input wire logic clk,
  // pins toward the device
  output logic cke,
  output logic reset_n,
  output logic odt,
  output logic [3:0] cmd,
  output logic [2:0] ba,
  output logic a10,
  output logic [sdpd_pkg::MR0_WR_W-1:0] mr0_wr,
  output logic mr0_ppd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cke = 1'h0;
    reset_n = 1'h1;
    odt = 1'h0;
    cmd = sdpd_pkg::CMD_NOP;
    ba = 3'h0;
    a10 = 1'h0;
    mr0_wr = 3'h0;
    mr0_ppd = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // released ba and a10 lines show the inverse, never the stale value; cmd returns to NOP
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic a);
    @(posedge clk);
    cmd <= c;
    ba <= b;
    a10 <= a;
    @(posedge clk);
    cmd <= sdpd_pkg::CMD_NOP;
    ba <= ~b;
    a10 <= ~a;
  endtask
  task automatic mrs(input logic [2:0] w, input logic p);
    @(posedge clk);
    cmd <= sdpd_pkg::CMD_MRS;
    mr0_wr <= w;
    mr0_ppd <= p;
    @(posedge clk);
    cmd <= sdpd_pkg::CMD_NOP;
    mr0_wr <= ~w;
    mr0_ppd <= ~p;
    tick(4);
  endtask
  task automatic set_odt(input logic v);
    @(posedge clk);
    odt <= v;
  endtask
  task automatic pd_enter;
    @(posedge clk);
    cke <= 1'h0;
    cmd <= sdpd_pkg::CMD_NOP;
    tick(TPD);
  endtask
  // no read is placed near an exit and the one refresh follows a fast exit, so dll timing stays safe
  task automatic pd_exit;
    @(posedge clk);
    cke <= 1'h1;
    cmd <= sdpd_pkg::CMD_NOP;
    tick(TXP);
  endtask
  task automatic rst_lo;
    @(posedge clk);
    reset_n <= 1'h0;
    cke <= 1'h0;
  endtask
  task automatic rst_hi;
    tick(RST_CYC);
    @(posedge clk);
    reset_n <= 1'h1;
    tick(3);
    @(posedge clk);
    cke <= 1'h1;
    tick(2);
  endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the power-down and reset block
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic cke, reset_n, odt, a10, mr0_ppd;
  logic [3:0] cmd;
  logic [2:0] ba, mr0_wr, wr_rec;
  logic in_buf, out_buf, dll_on, term_on, act_pd, pre_pd, in_reset;
  logic [7:0] ref_cnt;
  int n_mismatch = 0;
  int checked = 0;
  always #5 clk = ~clk;
  sdpd_top i_sdpd_top (.CLK(clk), .RSTN(rstn), .CKE(cke), .RESET_N(reset_n), .ODT(odt),
    .CMD(cmd), .BA(ba), .A10(a10), .MR0_WR(mr0_wr), .MR0_PPD(mr0_ppd), .IN_BUF_EN(in_buf),
    .OUT_BUF_EN(out_buf), .DLL_ON(dll_on), .TERM_ON(term_on), .ACT_PD(act_pd),
    .PRE_PD(pre_pd), .IN_RESET(in_reset), .WR_RECOVERY(wr_rec), .REF_COUNT(ref_cnt));
  sdpd_ctl_model i_sdpd_ctl_model (.clk(clk), .cke(cke), .reset_n(reset_n), .odt(odt),
    .cmd(cmd), .ba(ba), .a10(a10), .mr0_wr(mr0_wr), .mr0_ppd(mr0_ppd));
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_slow;
    i_sdpd_ctl_model.mrs(3'h5, 1'h0);
    i_sdpd_ctl_model.set_odt(1'h1);
    i_sdpd_ctl_model.tick(3);
    #1;
    `CHK(wr_rec, 3'h5)
    `CHK(term_on, 1'h1)
    i_sdpd_ctl_model.pd_enter();
    #1;
    `CHK(pre_pd, 1'h1)
    `CHK(act_pd, 1'h0)
    `CHK(dll_on, 1'h0)
    `CHK({in_buf, out_buf}, 2'h0)
    `CHK(term_on, 1'h0)
    i_sdpd_ctl_model.issue(sdpd_pkg::CMD_ACT, 3'h3, 1'h0);
    i_sdpd_ctl_model.mrs(3'h7, 1'h1);
    i_sdpd_ctl_model.pd_exit();
    #1;
    `CHK({pre_pd, in_buf}, 2'h1)
    `CHK(wr_rec, 3'h5)
    i_sdpd_ctl_model.pd_enter();
    #1;
    `CHK({pre_pd, dll_on}, 2'h2)
    i_sdpd_ctl_model.pd_exit();
    $display("slow exit test done");
  endtask
  task automatic t_fast;
    i_sdpd_ctl_model.mrs(3'h2, 1'h1);
    i_sdpd_ctl_model.pd_enter();
    #1;
    `CHK(wr_rec, 3'h2)
    `CHK({pre_pd, dll_on}, 2'h3)
    i_sdpd_ctl_model.pd_exit();
    i_sdpd_ctl_model.issue(sdpd_pkg::CMD_REF, 3'h0, 1'h0);
    i_sdpd_ctl_model.tick(2);
    #1;
    `CHK(ref_cnt, 8'h1)
    $display("fast exit test done");
  endtask
  task automatic t_active;
    i_sdpd_ctl_model.issue(sdpd_pkg::CMD_ACT, 3'h3, 1'h0);
    i_sdpd_ctl_model.tick(2);
    i_sdpd_ctl_model.pd_enter();
    #1;
    `CHK({act_pd, pre_pd, dll_on, in_buf}, 4'ha)
    i_sdpd_ctl_model.pd_exit();
    i_sdpd_ctl_model.issue(sdpd_pkg::CMD_PRE, 3'h0, 1'h1);
    i_sdpd_ctl_model.tick(2);
    i_sdpd_ctl_model.pd_enter();
    #1;
    `CHK({act_pd, pre_pd}, 2'h1)
    $display("active test done");
  endtask
  task automatic t_reset_pd;
    i_sdpd_ctl_model.rst_lo();
    #1;
    `CHK(in_reset, 1'h1)
    `CHK({act_pd, pre_pd}, 2'h0)
    `CHK({out_buf, term_on}, 2'h0)
    i_sdpd_ctl_model.rst_hi();
    #1;
    `CHK({in_reset, dll_on}, 2'h1)
    `CHK(ref_cnt, 8'h1)
    $display("reset test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    i_sdpd_ctl_model.rst_hi();
    #1;
    `CHK({in_reset, dll_on, in_buf, out_buf, act_pd, pre_pd}, 6'h1c)
    t_slow();
    t_fast();
    t_active();
    t_reset_pd();
    summarize();
  end
  // whole run is well under a thousand cycles
  initial begin
    #50000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
